// file: src/sdl_defines.svh
// constants of the six-channel decimating loader
// assumes inclusion by bare name from the loader and the bench files
`ifndef SDL_DEFINES_SVH
`define SDL_DEFINES_SVH
`define SDL_NUM_CH 6
`define SDL_WORD_W 10
`define SDL_WORD_MSB 9
`define SDL_IDX_W 3
`define SDL_CH_FIRST_UP 3'h0
`define SDL_CH_FIRST_DN 3'h5
`define SDL_LOAD_EDGES 3'h6
`define SDL_FIFO_DEPTH 4
`define SDL_ENTRY_W 13
`define SDL_WORD_RST 10'h000
`endif

// file: src/sdl_pkg.sv
// types of the six-channel decimating loader
// assumes nothing of its surroundings
package sdl_pkg;
    typedef enum logic [0:0] {
        SDL_SEQ_IDLE = 1'b0,
        SDL_SEQ_LOAD = 1'b1
    } sdl_seq_t;
endpackage

// file: src/sdl_word_if.sv
// valid/ready carrier for channel-indexed words
// assumes one sender and one receiver on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sdl_word_if #(parameter int WIDTH = 13);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport sender(output valid, output data, input ready);
    modport receiver(input valid, input data, output ready);
endinterface
`default_nettype wire

// file: src/sdl_fifo.sv
// small fifo between edge capture and channel latches
// assumes synchronous flush and a single clock
`timescale 1ns/1ps
`default_nettype none
module sdl_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic flush_in,
    sdl_word_if.receiver push,
    sdl_word_if.sender pop
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push_fire, pop_fire;

    assign push.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign pop.valid = (cnt_reg != '0);
    assign pop.data = mem_reg[rd_reg];
    assign push_fire = push.valid && push.ready;
    assign pop_fire = pop.valid && pop.ready;

    always_comb
    begin
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (flush_in)
        begin
            wr_next = '0;
            rd_next = '0;
            cnt_next = '0;
        end
        else
        begin
            if (push_fire)
            begin
                mem_next[wr_reg] = push.data;
                wr_next = AW'(wr_reg + 1'b1);
            end
            if (pop_fire)
                rd_next = AW'(rd_reg + 1'b1);
            if (push_fire && !pop_fire)
                cnt_next = (AW+1)'(cnt_reg + 1'b1);
            else if (pop_fire && !push_fire)
                cnt_next = (AW+1)'(cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem_reg[i] <= '0;
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    a_fifo_bound: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        push_fire && !pop_fire && !flush_in |=> cnt_reg == $past(cnt_reg) + 1'b1)
        else $error("fifo count did not follow a push");
    c_fifo_full: cover property (@(posedge clk_in) disable iff (!rst_b_in)
        !push.ready);
endmodule // sdl_fifo
`default_nettype wire

// file: src/sdl_loader.sv
// six-channel decimating loader: edge-stepped latches, parallel transfer
// assumes pixel_clk_in and all controls synchronous to clk_in, which
// samples each pixel clock phase at least twice
//
// Summary of operation
// - ten-bit words, bit nine most significant
// - edge select high rising, low falling
// - each active edge of a loading cycle loads next channel latch
// - direction low from channel 0 up, else 5 down
// - rising mode: start sampled previous rising edge
// - falling mode: start sampled previous falling edge
// - transfer on rising edge copies next falling
// - polarity high above midpoint, low below
// - standby debiases, resumes when released
// - valid start opens six-edge loading cycle
// - standby discards all stored channel words
// - transfer updates all six outputs together
`timescale 1ns/1ps
`default_nettype none
`include "sdl_defines.svh"
module sdl_loader (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic pixel_clk_in,
    input wire logic edge_select_in,
    input wire logic direction_select_in,
    input wire logic sequence_start_in,
    input wire logic output_transfer_in,
    input wire logic polarity_invert_in,
    input wire logic standby_request_in,
    input wire logic [`SDL_WORD_W-1:0] pixel_word_in,
    output logic load_ready_out,
    output logic sequence_busy_out,
    output logic standby_active_out,
    output logic channel_above_midpoint_out,
    output logic [`SDL_WORD_W-1:0] channel_output_0_out,
    output logic [`SDL_WORD_W-1:0] channel_output_1_out,
    output logic [`SDL_WORD_W-1:0] channel_output_2_out,
    output logic [`SDL_WORD_W-1:0] channel_output_3_out,
    output logic [`SDL_WORD_W-1:0] channel_output_4_out,
    output logic [`SDL_WORD_W-1:0] channel_output_5_out
);
    function automatic logic [`SDL_IDX_W-1:0] next_chan(
        input logic [`SDL_IDX_W-1:0] idx, input logic down);
        next_chan = down ? `SDL_IDX_W'(idx - 1'b1) : `SDL_IDX_W'(idx + 1'b1);
    endfunction

    sdl_word_if #(.WIDTH(`SDL_ENTRY_W)) cap_if ();
    sdl_word_if #(.WIDTH(`SDL_ENTRY_W)) drn_if ();

    sdl_fifo #(.WIDTH(`SDL_ENTRY_W), .DEPTH(`SDL_FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .flush_in(standby_request_in),
        .push(cap_if.receiver),
        .pop(drn_if.sender)
    );

    logic pclk_prev_reg;
    logic rise, fall, active_edge, copy_now;
    sdl_pkg::sdl_seq_t seq_reg, seq_next;
    logic start_seen_reg, start_seen_next;
    logic dir_reg, dir_next;
    logic [`SDL_IDX_W-1:0] chan_reg, chan_next, load_idx;
    logic [`SDL_IDX_W-1:0] left_reg, left_next;
    logic load_now;
    logic xfr_pend_reg, xfr_pend_next;
    logic [`SDL_WORD_W-1:0] latch_reg [`SDL_NUM_CH];
    logic [`SDL_WORD_W-1:0] latch_next [`SDL_NUM_CH];
    logic [`SDL_WORD_W-1:0] out_reg [`SDL_NUM_CH];
    logic [`SDL_WORD_W-1:0] out_next [`SDL_NUM_CH];
    logic above_mid_reg, standby_reg;

    assign rise = pixel_clk_in && !pclk_prev_reg;
    assign fall = !pixel_clk_in && pclk_prev_reg;
    assign active_edge = edge_select_in ? rise : fall;
    // a transfer stalls the drain so the copy sees a settled latch set
    assign copy_now = fall && xfr_pend_reg && !standby_request_in;
    assign load_ready_out = cap_if.ready;
    assign sequence_busy_out = (seq_reg == sdl_pkg::SDL_SEQ_LOAD);
    assign standby_active_out = standby_reg;
    assign channel_above_midpoint_out = above_mid_reg;
    assign channel_output_0_out = out_reg[0];
    assign channel_output_1_out = out_reg[1];
    assign channel_output_2_out = out_reg[2];
    assign channel_output_3_out = out_reg[3];
    assign channel_output_4_out = out_reg[4];
    assign channel_output_5_out = out_reg[5];
    assign cap_if.valid = load_now;
    assign cap_if.data = {load_idx, pixel_word_in};
    assign drn_if.ready = !copy_now;

    // sequencer: a word arriving while the fifo is full is dropped
    always_comb
    begin
        seq_next = seq_reg;
        start_seen_next = start_seen_reg;
        dir_next = dir_reg;
        chan_next = chan_reg;
        left_next = left_reg;
        load_now = 1'b0;
        load_idx = chan_reg;
        if (standby_request_in)
        begin
            seq_next = sdl_pkg::SDL_SEQ_IDLE;
            start_seen_next = 1'b0;
            left_next = '0;
        end
        else if (active_edge)
        begin
            start_seen_next = sequence_start_in;
            if (start_seen_reg)
            begin
                load_now = 1'b1;
                load_idx = direction_select_in ? `SDL_CH_FIRST_DN
                                               : `SDL_CH_FIRST_UP;
                dir_next = direction_select_in;
                chan_next = next_chan(load_idx, direction_select_in);
                left_next = `SDL_IDX_W'(`SDL_LOAD_EDGES - 1'b1);
                seq_next = sdl_pkg::SDL_SEQ_LOAD;
            end
            else if (seq_reg == sdl_pkg::SDL_SEQ_LOAD)
            begin
                load_now = 1'b1;
                chan_next = next_chan(chan_reg, dir_reg);
                left_next = `SDL_IDX_W'(left_reg - 1'b1);
                if (left_reg == `SDL_IDX_W'(1))
                    seq_next = sdl_pkg::SDL_SEQ_IDLE;
            end
        end
    end

    // latches and output stage
    always_comb
    begin
        latch_next = latch_reg;
        out_next = out_reg;
        xfr_pend_next = xfr_pend_reg;
        if (standby_request_in)
        begin
            for (int i = 0; i < `SDL_NUM_CH; i++)
            begin
                latch_next[i] = `SDL_WORD_RST;
                out_next[i] = `SDL_WORD_RST;
            end
            xfr_pend_next = 1'b0;
        end
        else
        begin
            if (drn_if.valid && drn_if.ready)
                latch_next[drn_if.data[`SDL_ENTRY_W-1:`SDL_WORD_W]] =
                    drn_if.data[`SDL_WORD_MSB:0];
            if (rise)
                xfr_pend_next = output_transfer_in;
            else if (copy_now)
                xfr_pend_next = 1'b0;
            if (copy_now)
                out_next = latch_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pclk_prev_reg <= 1'b0;
            seq_reg <= sdl_pkg::SDL_SEQ_IDLE;
            start_seen_reg <= 1'b0;
            dir_reg <= 1'b0;
            chan_reg <= '0;
            left_reg <= '0;
            xfr_pend_reg <= 1'b0;
            above_mid_reg <= 1'b0;
            standby_reg <= 1'b0;
            for (int i = 0; i < `SDL_NUM_CH; i++)
            begin
                latch_reg[i] <= `SDL_WORD_RST;
                out_reg[i] <= `SDL_WORD_RST;
            end
        end
        else
        begin
            pclk_prev_reg <= pixel_clk_in;
            seq_reg <= seq_next;
            start_seen_reg <= start_seen_next;
            dir_reg <= dir_next;
            chan_reg <= chan_next;
            left_reg <= left_next;
            xfr_pend_reg <= xfr_pend_next;
            above_mid_reg <= polarity_invert_in;
            standby_reg <= standby_request_in;
            latch_reg <= latch_next;
            out_reg <= out_next;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_edge_rise_only: assert property (
        load_now && edge_select_in |-> rise)
        else $error("load off a rising edge in rising mode");
    a_edge_fall_only: assert property (
        load_now && !edge_select_in |-> fall)
        else $error("load off a falling edge in falling mode");
    a_start_up: assert property (
        active_edge && start_seen_reg && !standby_request_in
        && !direction_select_in
        |-> load_idx == 3'h0 ##1 chan_reg == 3'h1 && left_reg == 3'h5)
        else $error("upward sequence did not start at channel 0");
    a_start_down: assert property (
        active_edge && start_seen_reg && !standby_request_in
        && direction_select_in |-> load_idx == 3'h5 ##1 chan_reg == 3'h4)
        else $error("downward sequence did not start at channel 5");
    a_load_cause: assert property (
        load_now |-> active_edge && (start_seen_reg || left_reg != 3'h0)
        && cap_if.data[9:0] == pixel_word_in)
        else $error("word loaded without a live sequence");
    // a pixel phase lasts several cycles, so the copy is keyed on the fall
    a_xfr_arm: assert property (
        rise && !standby_request_in
        |=> xfr_pend_reg == $past(output_transfer_in))
        else $error("transfer request not taken at a rising edge");
    a_xfr_copy: assert property (
        fall && xfr_pend_reg && !standby_request_in
        |=> out_reg[0] == $past(latch_reg[0])
        && out_reg[5] == $past(latch_reg[5]))
        else $error("transfer did not copy at the next falling edge");
    a_out_hold: assert property (
        !copy_now && !standby_request_in |=> $stable(out_reg[3]))
        else $error("output changed without a transfer");
    a_standby_clear: assert property (
        standby_request_in |=> latch_reg[2] == 10'h000
        && seq_reg == sdl_pkg::SDL_SEQ_IDLE && standby_active_out)
        else $error("standby did not discard stored words");
    a_polarity_mid: assert property (
        ##1 channel_above_midpoint_out == $past(polarity_invert_in))
        else $error("polarity output did not follow its input");

    c_full_cycle: cover property (load_now && left_reg == 3'h1);
    c_transfer: cover property (copy_now);
    c_standby: cover property (standby_request_in ##1 !standby_request_in);
endmodule // sdl_loader
`default_nettype wire

// file: tb/sdl_proc_model.sv
// image processor model: pixel clock, word bus and loading controls
// assumes the bench calls pix_phase once per pixel clock phase
`timescale 1ns/1ps
`default_nettype none
`include "sdl_defines.svh"
module sdl_proc_model #(
    parameter int PHASE_CYC = 3
) (
    input wire logic clk_in,
    output logic pixel_clk_out,
    output logic [`SDL_WORD_W-1:0] pixel_word_out,
    output logic sequence_start_out,
    output logic output_transfer_out
);
    initial
    begin
        pixel_clk_out = 1'h0;
        pixel_word_out = 10'h000;
        sequence_start_out = 1'h0;
        output_transfer_out = 1'h0;
    end

    // phases under one system cycle would be missed by the edge detector
    task automatic pix_phase(input logic lvl,
        input logic [`SDL_WORD_W-1:0] w, input logic st, input logic xf);
        @(negedge clk_in);
        pixel_clk_out = lvl;
        pixel_word_out = w;
        sequence_start_out = st;
        output_transfer_out = xf;
        repeat (PHASE_CYC) @(negedge clk_in);
    endtask
endmodule // sdl_proc_model
`default_nettype wire

// file: tb/six_channel_decimating_loader_test.sv
// self-checking bench of the six-channel loader against a queue-free model
// assumes the loader and the processor model compiled beforehand
`timescale 1ns/1ps
`default_nettype none
`include "sdl_defines.svh"
module six_channel_decimating_loader_test;
    logic clk_in;
    logic rst_b_in;
    logic pclk;
    logic edge_sel;
    logic dir_sel;
    logic start;
    logic xfer;
    logic pol;
    logic standby_request;
    logic [`SDL_WORD_W-1:0] word;
    logic ready;
    logic busy;
    logic above;
    logic standby_request_act;
    logic [`SDL_WORD_W-1:0] outs [6];
    int error_cnt;
    int num_checks;
    int seed;
    int lat [6];
    int exp_out [6];
    int cnt;
    int idx;
    int down;
    logic pend;
    logic armed;

    sdl_loader sdl_loader_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .pixel_clk_in(pclk),
        .edge_select_in(edge_sel), .direction_select_in(dir_sel),
        .sequence_start_in(start), .output_transfer_in(xfer),
        .polarity_invert_in(pol), .standby_request_in(standby_request),
        .pixel_word_in(word), .load_ready_out(ready),
        .sequence_busy_out(busy), .standby_active_out(standby_request_act),
        .channel_above_midpoint_out(above),
        .channel_output_0_out(outs[0]), .channel_output_1_out(outs[1]),
        .channel_output_2_out(outs[2]), .channel_output_3_out(outs[3]),
        .channel_output_4_out(outs[4]), .channel_output_5_out(outs[5]));

    sdl_proc_model sdl_proc_model_inst (
        .clk_in(clk_in), .pixel_clk_out(pclk), .pixel_word_out(word),
        .sequence_start_out(start), .output_transfer_out(xfer));

    initial
    begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic close_out();
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_word(input logic [`SDL_WORD_W-1:0] got,
        input logic [`SDL_WORD_W-1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t output word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t status bit %b expected %b", $time, got, exp);
        end
    endtask

    // standby loses everything, same as power-up
    task automatic mdl_clear();
        lat = '{0, 0, 0, 0, 0, 0};
        exp_out = lat;
        cnt = 6;
        idx = 0;
        pend = 1'h0;
        armed = 1'h0;
    endtask

    task automatic mdl_edge(input logic lvl, input logic [9:0] w,
        input logic st, input logic xf);
        if (standby_request)
            return;
        if (lvl)
            pend = xf;
        // copy first: a word landing on the same falling edge misses it
        if (!lvl && pend)
        begin
            exp_out = lat;
            pend = 1'h0;
        end
        if (lvl != edge_sel)
            return;
        // direction is read at the first loading edge, not the start edge
        if (armed)
        begin
            cnt = 0;
            down = dir_sel;
            idx = down ? 5 : 0;
        end
        if (cnt < 6)
        begin
            lat[idx] = w;
            idx = down ? idx - 1 : idx + 1;
            cnt++;
        end
        armed = st;
    endtask

    task automatic check_all();
        for (int i = 0; i < 6; i++)
            chk_word(outs[i], 10'(exp_out[i]));
        chk_bit(above, pol);
        chk_bit(standby_request_act, standby_request);
        chk_bit(ready, 1'h1);
        chk_bit(busy, 1'(cnt > 0 && cnt < 6));
    endtask

    // inactive phase carries the inverted word so a wrong edge shows
    task automatic pix_cycle(input logic st, input logic xf);
        logic [9:0] w;
        w = 10'($random(seed));
        dir_sel = 1'($random(seed));
        mdl_edge(1'h1, edge_sel ? w : ~w, st, xf);
        sdl_proc_model_inst.pix_phase(1'h1, edge_sel ? w : ~w, st, xf);
        mdl_edge(1'h0, edge_sel ? ~w : w, st, xf);
        sdl_proc_model_inst.pix_phase(1'h0, edge_sel ? ~w : w, st, xf);
        check_all();
    endtask

    task automatic group(input logic xf_last);
        pol = 1'($random(seed));
        pix_cycle(1'h1, 1'h0);
        repeat (6) pix_cycle(1'h0, 1'h0);
        pix_cycle(1'h0, xf_last);
    endtask

    initial
    begin
        seed = 45;
        error_cnt = 0;
        num_checks = 0;
        rst_b_in = 1'h0;
        edge_sel = 1'h1;
        dir_sel = 1'h0;
        pol = 1'h0;
        standby_request = 1'h0;
        down = 0;
        mdl_clear();
        repeat (16) @(negedge clk_in);
        rst_b_in = 1'h1;
        @(negedge clk_in);
        check_all();
        for (int m = 1; m >= 0; m--)
        begin
            edge_sel = 1'(m);
            repeat (3) group(1'h1);
            group(1'h0);
            repeat (2) pix_cycle(1'h0, 1'h0);
            pix_cycle(1'h0, 1'h1);
        end
        pix_cycle(1'h1, 1'h0);
        repeat (3) pix_cycle(1'h0, 1'h0);
        standby_request = 1'h1;
        mdl_clear();
        repeat (4) @(negedge clk_in);
        check_all();
        pix_cycle(1'h1, 1'h1);
        standby_request = 1'h0;
        repeat (2) @(negedge clk_in);
        pix_cycle(1'h0, 1'h1);
        group(1'h1);
        close_out();
    end

    // whole run is under a thousand cycles; this is ample margin
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule // six_channel_decimating_loader_test
`default_nettype wire
